/* hdl/pbvdo_pkg.sv */
package pbvdo_pkg;
  localparam int PW_DEPTH = 4;
  typedef logic [31:0] pbvdo_word_t;
  typedef logic [3:0] pbvdo_cmd_t;
  typedef logic [3:0] pbvdo_be_t;
  typedef logic [2:0] pbvdo_cnt_t;
  typedef logic [1:0] pbvdo_ptr_t;
  localparam pbvdo_cnt_t PW_FULL = 3'h4;
  localparam pbvdo_cnt_t CNT_ONE = 3'h1;
  localparam pbvdo_ptr_t PTR_ONE = 2'h1;
  // PCI bus commands
  localparam pbvdo_cmd_t CMD_IO_RD = 4'h2;
  localparam pbvdo_cmd_t CMD_IO_WR = 4'h3;
  localparam pbvdo_cmd_t CMD_MEM_RD = 4'h6;
  localparam pbvdo_cmd_t CMD_MEM_WR = 4'h7;
  localparam pbvdo_cmd_t CMD_CFG_RD = 4'hA;
  localparam pbvdo_cmd_t CMD_CFG_WR = 4'hB;
  localparam pbvdo_cmd_t CMD_MEM_RD_MUL = 4'hC;
  localparam pbvdo_cmd_t CMD_MEM_RD_LN = 4'hE;
  localparam pbvdo_cmd_t CMD_MEM_WR_INV = 4'hF;
  // Legacy graphics decode
  localparam pbvdo_word_t FB_LO = 32'h000A_0000;
  localparam pbvdo_word_t FB_HI = 32'h000B_FFFF;
  localparam pbvdo_word_t BIOS_BASE = 32'h000C_0000;
  localparam logic [15:0] IO_UPPER_ZERO = 16'h0000;
  localparam logic [9:0] VIO_A_LO = 10'h3B0;
  localparam logic [9:0] VIO_A_HI = 10'h3BB;
  localparam logic [9:0] VIO_B_LO = 10'h3C0;
  localparam logic [9:0] VIO_B_HI = 10'h3DF;
  localparam logic [9:0] PAL_MASK = 10'h3C6;
  localparam logic [9:0] PAL_WADDR = 10'h3C8;
  localparam logic [9:0] PAL_DATA = 10'h3C9;

  typedef enum logic [1:0] {CLS_NONE, CLS_POSTED, CLS_DLY_RD, CLS_DLY_WR}
    pbvdo_cls_t;
  typedef struct packed {
    pbvdo_cmd_t cmd;
    pbvdo_word_t addr;
    pbvdo_be_t be;
    pbvdo_word_t data;
  } pbvdo_txn_t;

  function automatic pbvdo_cls_t pbvdo_classify(input pbvdo_cmd_t cmd);
    case (cmd)
      CMD_MEM_WR, CMD_MEM_WR_INV: return CLS_POSTED;
      CMD_IO_WR, CMD_CFG_WR: return CLS_DLY_WR;
      CMD_IO_RD, CMD_CFG_RD, CMD_MEM_RD, CMD_MEM_RD_MUL, CMD_MEM_RD_LN:
        return CLS_DLY_RD;
      default: return CLS_NONE;
    endcase
  endfunction : pbvdo_classify

  function automatic logic pbvdo_fb_hit(input pbvdo_cmd_t cmd,
                                        input pbvdo_word_t addr);
    return (cmd inside {CMD_MEM_RD, CMD_MEM_RD_MUL, CMD_MEM_RD_LN,
      CMD_MEM_WR, CMD_MEM_WR_INV}) && addr >= FB_LO && addr <= FB_HI; // [RL3]
  endfunction : pbvdo_fb_hit

  // Bits 15:10 are not looked at, so the ranges alias every 1 kB
  function automatic logic pbvdo_io_low(input pbvdo_cmd_t cmd,
                                        input pbvdo_word_t addr);
    return (cmd == CMD_IO_RD || cmd == CMD_IO_WR) &&
      addr[31:16] == IO_UPPER_ZERO; // [RL6]
  endfunction : pbvdo_io_low

  function automatic logic pbvdo_vio_hit(input pbvdo_cmd_t cmd,
                                         input pbvdo_word_t addr);
    return pbvdo_io_low(cmd, addr) &&
      ((addr[9:0] >= VIO_A_LO && addr[9:0] <= VIO_A_HI) ||
       (addr[9:0] >= VIO_B_LO && addr[9:0] <= VIO_B_HI)); // [RL5]
  endfunction : pbvdo_vio_hit

  function automatic logic pbvdo_pal_hit(input pbvdo_cmd_t cmd,
                                         input pbvdo_word_t addr);
    return pbvdo_io_low(cmd, addr) && cmd == CMD_IO_WR &&
      (addr[9:0] inside {PAL_MASK, PAL_WADDR, PAL_DATA}); // [RL8]
  endfunction : pbvdo_pal_hit
endpackage : pbvdo_pkg

/* hdl/pbvdo_pw_if.sv */
interface pbvdo_pw_if;
  import pbvdo_pkg::*;
  logic push_valid;
  logic push_ready;
  pbvdo_txn_t push_txn;
  logic head_valid;
  pbvdo_txn_t head_txn;
  logic pop;
  pbvdo_cnt_t count;
  modport fifo (input push_valid, push_txn, pop,
                output push_ready, head_valid, head_txn, count);
  modport user (output push_valid, push_txn, pop,
                input push_ready, head_valid, head_txn, count);
endinterface : pbvdo_pw_if

/* hdl/pbvdo_pw_fifo.sv */
module pbvdo_pw_fifo (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_b_in,
  // Posted write queue
  pbvdo_pw_if.fifo pw_io
);
  import pbvdo_pkg::*;
  typedef struct packed {
    pbvdo_txn_t [PW_DEPTH-1:0] mem;
    pbvdo_ptr_t wr;
    pbvdo_ptr_t rd;
    pbvdo_cnt_t count;
  } pbvdo_fifo_st_t;
  pbvdo_fifo_st_t st_ff;
  pbvdo_fifo_st_t nxt_st;
  logic do_push;
  logic do_pop;

  always_comb
  begin
    nxt_st = st_ff;
    do_push = pw_io.push_valid && st_ff.count != PW_FULL;
    do_pop = pw_io.pop && st_ff.count != '0;
    if (do_push)
    begin
      nxt_st.mem[st_ff.wr] = pw_io.push_txn; // [RL15] [RL16]
      nxt_st.wr = st_ff.wr + PTR_ONE;
    end
    if (do_pop)
      nxt_st.rd = st_ff.rd + PTR_ONE; // [RL24]
    if (do_push && !do_pop)
      nxt_st.count = st_ff.count + CNT_ONE;
    else if (do_pop && !do_push)
      nxt_st.count = st_ff.count - CNT_ONE;
  end

  always_ff @(posedge clk_in or negedge rst_b_in)
    if (!rst_b_in)
      st_ff <= '0;
    else
      st_ff <= nxt_st;

  assign pw_io.push_ready = st_ff.count != PW_FULL;
  assign pw_io.head_valid = st_ff.count != '0;
  assign pw_io.head_txn = st_ff.mem[st_ff.rd];
  assign pw_io.count = st_ff.count;

  pw_grow_a: assert property ( // [RL15]
    @(posedge clk_in) disable iff (!rst_b_in)
    pw_io.push_valid && pw_io.push_ready && !pw_io.pop
    |=> pw_io.count == $past(pw_io.count) + CNT_ONE)
    else $error("posted write not given its own entry");
  pw_head_a: assert property ( // [RL24]
    @(posedge clk_in) disable iff (!rst_b_in)
    pw_io.push_valid && pw_io.count == '0
    |=> pw_io.head_valid && pw_io.head_txn == $past(pw_io.push_txn))
    else $error("oldest posted write not at queue head");
endmodule : pbvdo_pw_fifo

/* hdl/pbvdo_vga_decode.sv */
module pbvdo_vga_decode #(
  parameter bit SEC_SIDE = 1'b0
) (
  // Request seen on the bus
  input wire pbvdo_pkg::pbvdo_cmd_t cmd_in,
  input wire pbvdo_pkg::pbvdo_word_t addr_in,
  input wire logic win_hit_in,
  // Mode controls
  input wire logic vga_mode_in,
  input wire logic vga_snoop_in,
  // Decode result
  output logic claim_out,
  output logic single_out
);
  import pbvdo_pkg::*;
  logic vga_hit;

  // Expansion ROM area gets no extra decode here; windows alone cover it
  always_comb // [RL3] [RL5] [RL6] [RL7]
  begin
    vga_hit = pbvdo_fb_hit(cmd_in, addr_in) || pbvdo_vio_hit(cmd_in, addr_in);
    if (SEC_SIDE)
      claim_out = win_hit_in && !(vga_mode_in && vga_hit); // [RL2]
    else
      claim_out = win_hit_in || (vga_mode_in && vga_hit) || // [RL1] [RL10]
        (!vga_mode_in && vga_snoop_in &&
         pbvdo_pal_hit(cmd_in, addr_in)); // [RL8]
    single_out = !SEC_SIDE && vga_mode_in && pbvdo_fb_hit(cmd_in, addr_in)
      && pbvdo_classify(cmd_in) == CLS_DLY_RD; // [RL4]
  end
endmodule : pbvdo_vga_decode

/* hdl/pbvdo_bridge.sv */
// Overview of operation
// [RL1] VGA mode sends frame buffer and VGA I/O downstream, ignoring windows.
// [RL2] VGA mode: never claim secondary-side accesses to VGA memory or I/O.
// [RL3] Frame buffer decode spans 0x000A0000 to 0x000BFFFF inclusive.
// [RL4] Frame buffer reads: no prefetch, one data phase, original byte enables.
// [RL5] VGA I/O decode matches 0x3B0-0x3BB and 0x3C0-0x3DF.
// [RL6] I/O match ignores bits 15:10 and needs bits 31:16 zero.
// [RL7] No extra decode for the BIOS area from 0xC0000.
// [RL8] Snoop mode forwards palette writes to 0x3C6, 0x3C8, 0x3C9, aliased.
// [RL9] Snoop mode claims palette writes on the primary bus.
// [RL10] Both mode bits set behaves as VGA mode alone.
// [RL11] Memory writes are posted: done at initiator, buffered, written later.
// [RL12] I/O and config writes delayed: retried, queued, done on target first.
// [RL13] All reads are delayed: read data queued, returned to initiator later.
// [RL14] Delayed write termination is held and returned as a completion.
// [RL15] Writes are never combined or collapsed into one transaction.
// [RL16] Byte lanes of separate masked writes are never merged.
// [RL17] Ordering position is fixed only at a non-retry termination.
// [RL18] Retried requests may be accepted and completed in any order.
// [RL19] Initiators needing order wait per delayed transaction; retry fairly.
// [RL20] Initiators never make one retry depend on another's completion.
// [RL21] Opposite-direction writes are independent; both sides post at once.
// [RL22] Taking a posted write never waits on non-posted master transactions.
// [RL23] Posted writes are accepted whatever state delayed ones are in.
// [RL24] Posted writes complete on target in acceptance order.
// [RL25] Delayed requests never pass earlier same-direction posted writes.
// [RL26] Fair choice lets posted writes pass delayed requests.
// [RL27] Read completion waits for earlier same-direction posted writes.
module pbvdo_bridge (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_b_in,
  // Mode controls
  input wire logic vga_mode_in,
  input wire logic vga_snoop_in,
  // Target side, index 0 primary bus, 1 secondary bus
  input wire logic [1:0] tgt_valid_in,
  input wire pbvdo_pkg::pbvdo_cmd_t [1:0] tgt_cmd_in,
  input wire pbvdo_pkg::pbvdo_word_t [1:0] tgt_addr_in,
  input wire pbvdo_pkg::pbvdo_be_t [1:0] tgt_be_in,
  input wire pbvdo_pkg::pbvdo_word_t [1:0] tgt_data_in,
  input wire logic [1:0] tgt_win_hit_in,
  output logic [1:0] tgt_claim_out,
  output logic [1:0] tgt_done_out,
  output logic [1:0] tgt_retry_out,
  output pbvdo_pkg::pbvdo_word_t [1:0] tgt_rdata_out,
  // Master side, index 0 downstream, 1 upstream
  output logic [1:0] mst_valid_out,
  output pbvdo_pkg::pbvdo_cmd_t [1:0] mst_cmd_out,
  output pbvdo_pkg::pbvdo_word_t [1:0] mst_addr_out,
  output pbvdo_pkg::pbvdo_be_t [1:0] mst_be_out,
  output pbvdo_pkg::pbvdo_word_t [1:0] mst_data_out,
  output logic [1:0] mst_single_out,
  input wire logic [1:0] mst_done_in,
  input wire logic [1:0] mst_retry_in,
  input wire pbvdo_pkg::pbvdo_word_t [1:0] mst_rdata_in
);
  import pbvdo_pkg::*;

  typedef struct packed {
    logic busy;
    logic issued;
    logic is_rd;
    logic single;
    pbvdo_txn_t txn;
    pbvdo_word_t rdata;
    pbvdo_cnt_t ahead;
    pbvdo_cnt_t wait_cnt;
  } pbvdo_dly_t;
  typedef struct packed {
    logic active;
    logic sel_dly;
    logic fair;
    logic single;
    pbvdo_txn_t txn;
  } pbvdo_mst_t;
  typedef struct packed {
    logic claim;
    logic done;
    logic retry;
    pbvdo_word_t rdata;
  } pbvdo_rsp_t;
  typedef struct packed {
    pbvdo_dly_t [1:0] dly;
    pbvdo_mst_t [1:0] mst;
    pbvdo_rsp_t [1:0] rsp;
  } pbvdo_st_t;

  pbvdo_st_t st_ff;
  pbvdo_st_t nxt_st;
  logic [1:0] claim;
  logic [1:0] single_rd;
  logic [1:0] push_v;
  logic [1:0] push_rdy;
  logic [1:0] pop;
  logic [1:0] head_v;
  pbvdo_txn_t [1:0] head;
  pbvdo_txn_t [1:0] req;
  pbvdo_cnt_t [1:0] cnt;
  pbvdo_cls_t cls;
  logic cand_pw;
  logic cand_dly;
  logic sel;
  logic match;
  int o;

  // One posted queue and one decoder per direction, keyed by source bus
  for (genvar g = 0; g < 2; g++)
  begin : gen_dir
    pbvdo_pw_if pw ();
    pbvdo_pw_fifo u_fifo (
      .clk_in(clk_in),
      .rst_b_in(rst_b_in),
      .pw_io(pw)
    );
    pbvdo_vga_decode #(.SEC_SIDE(g == 1)) u_dec (
      .cmd_in(tgt_cmd_in[g]),
      .addr_in(tgt_addr_in[g]),
      .win_hit_in(tgt_win_hit_in[g]),
      .vga_mode_in(vga_mode_in),
      .vga_snoop_in(vga_snoop_in),
      .claim_out(claim[g]),
      .single_out(single_rd[g])
    );
    assign req[g] = '{cmd: tgt_cmd_in[g], addr: tgt_addr_in[g],
                      be: tgt_be_in[g], data: tgt_data_in[g]};
    assign pw.push_valid = push_v[g];
    assign pw.push_txn = req[g];
    assign pw.pop = pop[g];
    assign push_rdy[g] = pw.push_ready;
    assign head_v[g] = pw.head_valid;
    assign head[g] = pw.head_txn;
    assign cnt[g] = pw.count;
  end

  always_comb
  begin
    nxt_st = st_ff;
    push_v = '0;
    pop = '0;
    cls = CLS_NONE;
    cand_pw = 1'b0;
    cand_dly = 1'b0;
    sel = 1'b0;
    match = 1'b0;
    o = 0;
    for (int d = 0; d < 2; d++)
      pop[d] = st_ff.mst[d].active && !st_ff.mst[d].sel_dly && mst_done_in[d];
    for (int d = 0; d < 2; d++)
    begin
      o = 1 - d;
      nxt_st.rsp[d].claim = 1'b0;
      nxt_st.rsp[d].done = 1'b0;
      nxt_st.rsp[d].retry = 1'b0;
      if (pop[d] && st_ff.dly[d].ahead != '0)
        nxt_st.dly[d].ahead = st_ff.dly[d].ahead - CNT_ONE; // [RL25]
      if (pop[o] && st_ff.dly[d].wait_cnt != '0)
        nxt_st.dly[d].wait_cnt = st_ff.dly[d].wait_cnt - CNT_ONE; // [RL27]
      // Target side on bus d
      cls = pbvdo_classify(tgt_cmd_in[d]);
      match = st_ff.dly[d].busy && st_ff.dly[d].txn.cmd == tgt_cmd_in[d] &&
        st_ff.dly[d].txn.addr == tgt_addr_in[d] &&
        st_ff.dly[d].txn.be == tgt_be_in[d] &&
        (st_ff.dly[d].is_rd || st_ff.dly[d].txn.data == tgt_data_in[d]);
      if (tgt_valid_in[d] && claim[d] && cls != CLS_NONE)
      begin
        nxt_st.rsp[d].claim = 1'b1; // [RL9]
        if (cls == CLS_POSTED)
        begin
          // Only queue room matters, never the delayed slot
          push_v[d] = push_rdy[d]; // [RL11] [RL22] [RL23]
          nxt_st.rsp[d].done = push_rdy[d];
          nxt_st.rsp[d].retry = !push_rdy[d];
        end
        else if (match && st_ff.dly[d].issued &&
                 (!st_ff.dly[d].is_rd || st_ff.dly[d].wait_cnt == '0))
        begin
          nxt_st.rsp[d].done = 1'b1; // [RL13] [RL14] [RL27]
          nxt_st.rsp[d].rdata = st_ff.dly[d].rdata;
          nxt_st.dly[d].busy = 1'b0;
        end
        else
        begin
          // Other requests retry until the slot frees, in any order
          nxt_st.rsp[d].retry = 1'b1; // [RL12] [RL18]
          if (!st_ff.dly[d].busy)
          begin
            nxt_st.dly[d].busy = 1'b1;
            nxt_st.dly[d].issued = 1'b0;
            nxt_st.dly[d].is_rd = cls == CLS_DLY_RD;
            nxt_st.dly[d].single = single_rd[d]; // [RL4]
            nxt_st.dly[d].txn = req[d];
            nxt_st.dly[d].ahead = pbvdo_cnt_t'(cnt[d] - pop[d]); // [RL25]
            nxt_st.dly[d].wait_cnt = '0;
          end
        end
      end
      // Master side for direction d, both directions run at once
      if (st_ff.mst[d].active) // [RL21]
      begin
        if (mst_done_in[d] || mst_retry_in[d])
          nxt_st.mst[d].active = 1'b0;
        if (mst_done_in[d] && st_ff.mst[d].sel_dly)
        begin
          nxt_st.dly[d].issued = 1'b1; // [RL17]
          nxt_st.dly[d].rdata = mst_rdata_in[d];
          nxt_st.dly[d].wait_cnt = pbvdo_cnt_t'(cnt[o] - pop[o]); // [RL27]
        end
      end
      else
      begin
        cand_pw = head_v[d]; // [RL24]
        cand_dly = st_ff.dly[d].busy && !st_ff.dly[d].issued &&
          st_ff.dly[d].ahead == '0; // [RL25]
        sel = cand_dly && (!cand_pw || st_ff.mst[d].fair); // [RL26]
        if (cand_pw || cand_dly)
        begin
          nxt_st.mst[d].active = 1'b1;
          nxt_st.mst[d].sel_dly = sel;
          nxt_st.mst[d].txn = sel ? st_ff.dly[d].txn : head[d]; // [RL16]
          nxt_st.mst[d].single = sel && st_ff.dly[d].single; // [RL4]
          if (cand_pw && cand_dly)
            nxt_st.mst[d].fair = !st_ff.mst[d].fair; // [RL26]
        end
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in)
    if (!rst_b_in)
      st_ff <= '0;
    else
      st_ff <= nxt_st;

  for (genvar g = 0; g < 2; g++)
  begin : gen_out
    assign tgt_claim_out[g] = st_ff.rsp[g].claim;
    assign tgt_done_out[g] = st_ff.rsp[g].done;
    assign tgt_retry_out[g] = st_ff.rsp[g].retry;
    assign tgt_rdata_out[g] = st_ff.rsp[g].rdata;
    assign mst_valid_out[g] = st_ff.mst[g].active;
    assign mst_cmd_out[g] = st_ff.mst[g].txn.cmd;
    assign mst_addr_out[g] = st_ff.mst[g].txn.addr;
    assign mst_be_out[g] = st_ff.mst[g].txn.be;
    assign mst_data_out[g] = st_ff.mst[g].txn.data;
    assign mst_single_out[g] = st_ff.mst[g].single;
  end

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_b_in);

  sequence dly_first_s;
    tgt_valid_in[0] && claim[0] && !st_ff.dly[0].busy &&
      pbvdo_classify(tgt_cmd_in[0]) inside {CLS_DLY_RD, CLS_DLY_WR};
  endsequence
  sequence retry_resp_s;
    tgt_retry_out[0] && !tgt_done_out[0] && tgt_claim_out[0];
  endsequence
  sequence rd_early_s;
    tgt_valid_in[0] && claim[0] && st_ff.dly[0].busy &&
      st_ff.dly[0].is_rd && st_ff.dly[0].wait_cnt != '0;
  endsequence

  vga_claim_a: assert property ( // [RL1]
    tgt_valid_in[0] && vga_mode_in && tgt_cmd_in[0] != CMD_CFG_RD &&
    (pbvdo_fb_hit(tgt_cmd_in[0], tgt_addr_in[0]) ||
     pbvdo_vio_hit(tgt_cmd_in[0], tgt_addr_in[0])) |=> tgt_claim_out[0])
    else $error("VGA access on primary bus not claimed");
  sec_ignore_a: assert property ( // [RL2]
    tgt_valid_in[1] && vga_mode_in &&
    (pbvdo_fb_hit(tgt_cmd_in[1], tgt_addr_in[1]) ||
     pbvdo_vio_hit(tgt_cmd_in[1], tgt_addr_in[1])) |=> !tgt_claim_out[1])
    else $error("VGA access on secondary bus was claimed");
  bios_skip_a: assert property ( // [RL7]
    tgt_valid_in[0] && !tgt_win_hit_in[0] && tgt_addr_in[0] == BIOS_BASE
    |=> !tgt_claim_out[0])
    else $error("BIOS area decoded outside the windows");
  io_upper_a: assert property ( // [RL6]
    tgt_valid_in[0] && !tgt_win_hit_in[0] && tgt_cmd_in[0] == CMD_IO_RD &&
    tgt_addr_in[0][31:16] != IO_UPPER_ZERO |=> !tgt_claim_out[0])
    else $error("I/O above 64 kB decoded as VGA");
  snoop_claim_a: assert property ( // [RL9]
    tgt_valid_in[0] && vga_snoop_in &&
    pbvdo_pal_hit(tgt_cmd_in[0], tgt_addr_in[0])
    |=> tgt_claim_out[0] && (tgt_done_out[0] || tgt_retry_out[0]))
    else $error("palette write not claimed");
  dly_retry_a: assert property ( // [RL12]
    dly_first_s |=> retry_resp_s ##0 st_ff.dly[0].busy)
    else $error("first delayed request not retried and queued");
  posted_done_a: assert property ( // [RL11]
    tgt_valid_in[1] && claim[1] && push_rdy[1] &&
    pbvdo_classify(tgt_cmd_in[1]) == CLS_POSTED
    |=> tgt_done_out[1] && !tgt_retry_out[1] && head_v[1])
    else $error("posted write not completed at initiator");
  both_post_a: assert property ( // [RL21]
    tgt_valid_in == 2'h3 && claim == 2'h3 && push_rdy == 2'h3 &&
    pbvdo_classify(tgt_cmd_in[0]) == CLS_POSTED &&
    pbvdo_classify(tgt_cmd_in[1]) == CLS_POSTED |=> tgt_done_out == 2'h3)
    else $error("simultaneous posted writes not both accepted");
  rd_wait_a: assert property ( // [RL27]
    rd_early_s |=> !tgt_done_out[0])
    else $error("read completion passed earlier posted write");
  dly_order_a: assert property ( // [RL25]
    $rose(mst_valid_out[0]) && st_ff.mst[0].sel_dly
    |-> $past(st_ff.dly[0].ahead) == '0)
    else $error("delayed request passed queued posted write");
  fb_single_a: assert property ( // [RL4]
    dly_first_s ##0 vga_mode_in &&
    pbvdo_fb_hit(tgt_cmd_in[0], tgt_addr_in[0]) &&
    pbvdo_classify(tgt_cmd_in[0]) == CLS_DLY_RD
    |=> st_ff.dly[0].single && st_ff.dly[0].txn.be == $past(tgt_be_in[0]))
    else $error("frame buffer read not single phase");
  mst_hold_a: assert property ( // [RL24]
    mst_valid_out[0] && !mst_done_in[0] && !mst_retry_in[0]
    |=> mst_valid_out[0] && $stable(mst_addr_out[0]) &&
        $stable(mst_data_out[0]))
    else $error("master request changed before termination");
endmodule : pbvdo_bridge

/* bench/pbvdo_tgt_model.sv */
module pbvdo_tgt_model
  import pbvdo_pkg::*;
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_b_in,
  // Issued transactions
  input wire logic [1:0] valid_in,
  input wire pbvdo_pkg::pbvdo_word_t [1:0] addr_in,
  input wire logic [1:0] rty_in,
  // Termination
  output logic [1:0] done_out,
  output logic [1:0] retry_out,
  output pbvdo_pkg::pbvdo_word_t [1:0] rdata_out
);
  timeunit 1ns;
  timeprecision 1ns;
  import pbvdo_pkg::*;

  // Answers on the falling edge after the issue, half a cycle later; valid drops before the next answer
  always @(negedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      done_out <= 2'h0;
      retry_out <= 2'h0;
      rdata_out <= '0;
    end
    else
      for (int d = 0; d < 2; d++)
      begin
        done_out[d] <= valid_in[d] && !rty_in[d];
        retry_out[d] <= valid_in[d] && rty_in[d];
        // Data outside an answer keeps changing
        rdata_out[d] <= valid_in[d] ? (addr_in[d] ^ 32'h5A5A_5A5A) :
          ~rdata_out[d];
      end
  end
endmodule : pbvdo_tgt_model

/* bench/pbvdo_bridge_tb.sv */
module pbvdo_bridge_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import pbvdo_pkg::*;
  logic clk_in = 1'b0;
  logic rst_b_in = 1'b0;
  logic vga_mode_in = 1'b0;
  logic vga_snoop_in = 1'b0;
  logic [1:0] tgt_valid_in = 2'h0;
  pbvdo_cmd_t [1:0] tgt_cmd_in = '0;
  pbvdo_word_t [1:0] tgt_addr_in = '0;
  pbvdo_be_t [1:0] tgt_be_in = '0;
  pbvdo_word_t [1:0] tgt_data_in = '0;
  logic [1:0] tgt_win_hit_in = 2'h0;
  logic [1:0] tgt_claim_out, tgt_done_out, tgt_retry_out;
  pbvdo_word_t [1:0] tgt_rdata_out, mst_addr_out, mst_data_out, mst_rdata_in;
  logic [1:0] mst_valid_out, mst_single_out, mst_done_in, mst_retry_in;
  pbvdo_cmd_t [1:0] mst_cmd_out;
  pbvdo_be_t [1:0] mst_be_out;
  logic [1:0] rty = 2'h0;
  int fails = 0;
  int total_checks = 0;
  pbvdo_txn_t lg[2][$];
  logic sg[$];

  pbvdo_bridge dut (.clk_in, .rst_b_in, .vga_mode_in, .vga_snoop_in,
    .tgt_valid_in, .tgt_cmd_in, .tgt_addr_in, .tgt_be_in, .tgt_data_in,
    .tgt_win_hit_in, .tgt_claim_out, .tgt_done_out, .tgt_retry_out,
    .tgt_rdata_out, .mst_valid_out, .mst_cmd_out, .mst_addr_out,
    .mst_be_out, .mst_data_out, .mst_single_out, .mst_done_in,
    .mst_retry_in, .mst_rdata_in);
  pbvdo_tgt_model tgt (.clk_in, .rst_b_in, .valid_in(mst_valid_out),
    .addr_in(mst_addr_out), .rty_in(rty), .done_out(mst_done_in),
    .retry_out(mst_retry_in), .rdata_out(mst_rdata_in));

  initial
  begin
    forever #20 clk_in = ~clk_in;
  end

  // Log of every transaction completed on a target bus
  always @(posedge clk_in)
    for (int d = 0; d < 2; d++)
      if (mst_valid_out[d] === 1'b1 && mst_done_in[d] === 1'b1)
      begin
        lg[d].push_back({mst_cmd_out[d], mst_addr_out[d], mst_be_out[d],
          mst_data_out[d]});
        if (d == 0)
          sg.push_back(mst_single_out[0]);
      end

  task automatic chk(input logic [63:0] seen, input logic [63:0] exp,
                     input string msg);
    total_checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask : chk

  task automatic summarize;
    $display("checks %0d, mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : summarize

  task automatic hang(input string msg);
    chk(1, 0, msg);
    summarize();
  endtask : hang

  // One attempt; answer is {claim, done, retry}
  task automatic req(input int b, input pbvdo_cmd_t c, input pbvdo_word_t a,
    input pbvdo_be_t be, input logic win, output logic [2:0] r,
    output pbvdo_word_t rd);
    tgt_cmd_in[b] = c;
    tgt_addr_in[b] = a;
    tgt_be_in[b] = be;
    tgt_data_in[b] = a ^ 32'h0000_FFFF;
    tgt_win_hit_in[b] = win;
    tgt_valid_in[b] = 1'b1;
    r = 3'h0;
    for (int i = 0; i < 2; i++)
    begin
      @(negedge clk_in);
      tgt_valid_in[b] = 1'b0;
      r |= {tgt_claim_out[b], tgt_done_out[b], tgt_retry_out[b]};
      if (tgt_done_out[b] === 1'b1)
        rd = tgt_rdata_out[b];
    end
  endtask : req

  task automatic xfer(input int b, input pbvdo_cmd_t c, input pbvdo_word_t a,
    input pbvdo_be_t be, input logic win, output logic [2:0] r,
    output pbvdo_word_t rd);
    req(b, c, a, be, win, r, rd);
    // Same request repeated alone until it completes
    for (int n = 0; r === 3'b101; n++)
    begin
      if (n == 200)
        hang("request never completed");
      repeat (3) @(negedge clk_in);
      req(b, c, a, be, win, r, rd);
    end
  endtask : xfer

  task automatic drain;
    repeat (3) @(negedge clk_in);
    for (int n = 0; mst_valid_out !== 2'h0; n++)
    begin
      if (n == 300)
        hang("queue never drained");
      @(negedge clk_in);
    end
  endtask : drain

  task automatic probe(input int b, input logic [1:0] md,
    input pbvdo_cmd_t c, input pbvdo_word_t a, input logic win,
    input logic exp);
    logic [2:0] r;
    pbvdo_word_t rd;
    int n;
    n = lg[b].size();
    {vga_mode_in, vga_snoop_in} = md;
    xfer(b, c, a, 4'hF, win, r, rd);
    drain();
    chk(r[2], exp, "claim");
    chk(lg[b].size(), n + exp, "forward count");
    if (exp)
    begin
      chk(lg[b][$].addr, a, "forwarded address");
      chk({lg[b][$].cmd, lg[b][$].data}, {c, a ^ 32'h0000_FFFF},
        "forwarded command and data");
    end
  endtask : probe

  task automatic t_decode;
    probe(0, 2'b10, CMD_MEM_WR, 32'h0009_FFFF, 1'b0, 1'b0);
    probe(0, 2'b10, CMD_MEM_WR, 32'h000A_0000, 1'b0, 1'b1);
    probe(0, 2'b10, CMD_MEM_RD, 32'h000B_FFFF, 1'b0, 1'b1);
    probe(0, 2'b10, CMD_MEM_WR, 32'h000C_0000, 1'b0, 1'b0);
    probe(0, 2'b10, CMD_IO_RD, 32'h0000_03BB, 1'b0, 1'b1);
    probe(0, 2'b10, CMD_IO_RD, 32'h0000_03BC, 1'b0, 1'b0);
    probe(0, 2'b10, CMD_IO_WR, 32'h0000_FFDF, 1'b0, 1'b1);
    probe(0, 2'b10, CMD_IO_WR, 32'h0001_03C0, 1'b0, 1'b0);
    probe(0, 2'b01, CMD_IO_WR, 32'h0000_03C6, 1'b0, 1'b1);
    probe(0, 2'b01, CMD_IO_WR, 32'h0000_1FC9, 1'b0, 1'b1);
    probe(0, 2'b01, CMD_IO_RD, 32'h0000_03C8, 1'b0, 1'b0);
    probe(0, 2'b01, CMD_IO_WR, 32'h0000_03C7, 1'b0, 1'b0);
    probe(0, 2'b11, CMD_IO_WR, 32'h0000_03C7, 1'b0, 1'b1);
    probe(0, 2'b00, CMD_IO_WR, 32'h0000_03C8, 1'b0, 1'b0);
    probe(1, 2'b10, CMD_MEM_RD, 32'h000A_0000, 1'b1, 1'b0);
    probe(1, 2'b10, CMD_IO_WR, 32'h0000_03B0, 1'b1, 1'b0);
    probe(1, 2'b10, CMD_MEM_WR, 32'h0010_0000, 1'b1, 1'b1);
    $display("test decode done");
  endtask : t_decode

  task automatic t_order;
    logic [2:0] r;
    pbvdo_word_t rd;
    int n;
    int ri;
    vga_mode_in = 1'b1;
    vga_snoop_in = 1'b0;
    rty[0] = 1'b1;
    n = lg[0].size();
    for (int i = 0; i < 3; i++)
    begin
      req(0, CMD_MEM_WR, 32'h000A_0010, 4'h1 << i, 1'b0, r, rd);
      chk(r, 3'b110, "posted accepted");
    end
    req(0, CMD_MEM_RD, 32'h000A_0020, 4'h3, 1'b0, r, rd);
    chk(r, 3'b101, "read retried");
    req(0, CMD_MEM_WR_INV, 32'h000A_0010, 4'h8, 1'b0, r, rd);
    chk(r, 3'b110, "posted beside delayed");
    req(0, CMD_MEM_WR, 32'h000A_0030, 4'hF, 1'b0, r, rd);
    chk(r, 3'b101, "full queue");
    rty[0] = 1'b0;
    xfer(0, CMD_MEM_RD, 32'h000A_0020, 4'h3, 1'b0, r, rd);
    chk(rd, 32'h000A_0020 ^ 32'h5A5A_5A5A, "read data");
    drain();
    chk(lg[0].size(), n + 5, "no merge");
    ri = 0;
    for (int i = 0; i < 5; i++)
      if (lg[0][n + i].cmd === CMD_MEM_RD)
        ri = i;
    for (int i = 0; i < 3; i++)
      chk(lg[0][n + i].be, 4'h1 << i, "posted order");
    chk(ri >= 3, 1, "read after writes");
    chk({lg[0][n + ri].be, sg[n + ri]}, 5'h07, "single phase");
    $display("test order done");
  endtask : t_order

  task automatic t_pull;
    logic [2:0] r;
    pbvdo_word_t rd;
    int n;
    rty[1] = 1'b1;
    n = lg[1].size();
    req(1, CMD_MEM_WR, 32'h0010_0040, 4'hF, 1'b1, r, rd);
    req(0, CMD_MEM_RD, 32'h000A_0050, 4'hF, 1'b0, r, rd);
    repeat (6) @(negedge clk_in);
    req(0, CMD_MEM_RD, 32'h000A_0050, 4'hF, 1'b0, r, rd);
    chk(r, 3'b101, "read held behind write");
    rty[1] = 1'b0;
    xfer(0, CMD_MEM_RD, 32'h000A_0050, 4'hF, 1'b0, r, rd);
    chk(lg[1].size(), n + 1, "write done before read");
    $display("test pull done");
  endtask : t_pull

  task automatic t_both;
    logic [3:0] r;
    vga_mode_in = 1'b1;
    tgt_cmd_in = {CMD_MEM_WR, CMD_MEM_WR};
    tgt_addr_in = {32'h0010_0000, 32'h000A_0040};
    tgt_win_hit_in = 2'h2;
    tgt_be_in = 8'hFF;
    tgt_valid_in = 2'h3;
    r = 4'h0;
    for (int i = 0; i < 2; i++)
    begin
      @(negedge clk_in);
      tgt_valid_in = 2'h0;
      r |= {tgt_claim_out, tgt_done_out};
    end
    chk(r, 4'hF, "both posted");
    drain();
    chk(lg[0][$].addr, 32'h000A_0040, "downstream write");
    chk(lg[1][$].addr, 32'h0010_0000, "upstream write");
    $display("test both done");
  endtask : t_both

  initial
  begin
    repeat (16) @(negedge clk_in);
    chk({mst_valid_out, tgt_claim_out, tgt_done_out}, 0, "idle in reset");
    rst_b_in = 1'b1;
    @(negedge clk_in);
    chk({mst_valid_out, tgt_retry_out}, 0, "idle after reset");
    t_decode();
    t_order();
    t_pull();
    t_both();
    summarize();
  end
endmodule : pbvdo_bridge_tb
